// ### verilog/slo_top.sv
/*
 * Decode and execute of the push-literal, pointer-subtract and
 * subtract-and-return instructions on three indirect pointers.
 * Assumes the core offers opcodes in Q1, owns data memory, the
 * status flags and the return stack, and shares the core reset.
 */
// Summary of operation
// - Push writes low opcode byte at stack pointer
// - Push then decrements stack pointer by one
// - Push is one word, one cycle
// - Pointer subtract: six-bit literal from selected pointer
// - Subtract-and-return subtracts from stack pointer only
// - Then loads program counter from return stack top
// - Two cycles; second cycle is all no-operation
// - Select field binary 11 means subtract-and-return
// - Recognised only with extended set enabled
`timescale 1ns/100ps
`default_nettype none
`include "slo_defines.svh"

module slo_top #(
    parameter int PTR_W = 12,
    parameter int PC_W = 21
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_ext_enable,
    input wire logic i_op_valid,
    input wire logic [15:0] i_opcode,
    input wire logic [PC_W-1:0] i_return_stack_top,
    input wire logic i_ptr_load,
    input wire logic [1:0] i_ptr_load_sel,
    input wire logic [PTR_W-1:0] i_ptr_load_value,
    output logic o_op_ready,
    output logic o_op_taken,
    output logic o_mem_write,
    output logic [PTR_W-1:0] o_mem_addr,
    output logic [7:0] o_mem_wdata,
    output logic o_pc_load,
    output logic [PC_W-1:0] o_pc_value,
    output logic o_status_write,
    output logic [PTR_W-1:0] o_pointer0,
    output logic [PTR_W-1:0] o_pointer1,
    output logic [PTR_W-1:0] o_pointer2
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic slo_pkg::slo_op_t decode_op(input logic [15:0] op, input logic ext);
        decode_op = slo_pkg::OP_NONE;
        if (ext && op[15:8] == `SLO_OP_PUSH_HI) begin
            decode_op = slo_pkg::OP_PUSH;
        end else if (ext && op[15:8] == `SLO_OP_SUB_HI) begin
            if (op[`SLO_SEL_MSB:`SLO_SEL_LSB] == `SLO_SEL_RETURN) begin
                decode_op = slo_pkg::OP_SUBRET;
            end else begin
                decode_op = slo_pkg::OP_SUB;
            end
        end
    endfunction

    function automatic logic [PTR_W-1:0] sub_lit(input logic [PTR_W-1:0] p, input logic [5:0] k);
        sub_lit = p - {{(PTR_W-6){1'b0}}, k};
    endfunction

    // ------------------------------------------------------------
    // Phase sequencer
    // ------------------------------------------------------------
    slo_phase_if phs ();

    slo_phase_seq u_seq (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .phs(phs.seq)
    );

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    slo_pkg::slo_exec_t state;
    slo_pkg::slo_exec_t next_state;
    slo_pkg::slo_op_t op_kind;
    slo_pkg::slo_op_t next_op_kind;
    logic [15:0] op_word;
    logic [PTR_W-1:0] ptr [3];
    logic [PTR_W-1:0] next_ptr [3];

    wire in_q1 = (phs.phase == slo_pkg::PH_Q1);
    wire in_q4 = phs.cycle_end;
    wire slo_pkg::slo_op_t dec_kind = decode_op(i_opcode, i_ext_enable);
    wire accept = in_q1 && i_op_valid && (state == slo_pkg::EX_RUN);
    wire [7:0] lit8 = op_word[`SLO_LIT8_MSB:0];
    wire [5:0] lit6 = op_word[`SLO_LIT6_MSB:0];
    wire [1:0] sel = op_word[`SLO_SEL_MSB:`SLO_SEL_LSB];
    wire exec = in_q4 && (op_kind != slo_pkg::OP_NONE);
    wire exec_push = exec && (op_kind == slo_pkg::OP_PUSH);
    wire exec_sub = exec && (op_kind == slo_pkg::OP_SUB) && (sel <= `SLO_SEL_MAX);
    wire exec_ret = exec && (op_kind == slo_pkg::OP_SUBRET);

    assign o_op_ready = in_q1 && (state == slo_pkg::EX_RUN);
    assign o_op_taken = accept && (dec_kind != slo_pkg::OP_NONE);

    always_comb begin
        next_op_kind = op_kind;
        if (accept) begin
            next_op_kind = dec_kind;
        end else if (in_q4) begin
            next_op_kind = slo_pkg::OP_NONE;
        end
    end

    // ------------------------------------------------------------
    // Cycle state
    // ------------------------------------------------------------
    always_comb begin
        case (state)
            slo_pkg::EX_RUN: next_state = exec_ret ? slo_pkg::EX_NOP : slo_pkg::EX_RUN;
            slo_pkg::EX_NOP: next_state = in_q4 ? slo_pkg::EX_RUN : slo_pkg::EX_NOP;
            default: next_state = slo_pkg::EX_RUN;
        endcase
    end

    // ------------------------------------------------------------
    // Pointer update
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            next_ptr[i] = ptr[i];
        end
        if (i_ptr_load && i_ptr_load_sel <= `SLO_SEL_MAX) begin
            next_ptr[i_ptr_load_sel] = i_ptr_load_value;
        end
        if (exec_push) begin
            next_ptr[`SLO_STACK_PTR] = PTR_W'(ptr[`SLO_STACK_PTR] - `SLO_PUSH_STEP);
        end
        if (exec_sub) begin
            next_ptr[sel] = sub_lit(ptr[sel], lit6);
        end
        if (exec_ret) begin
            next_ptr[`SLO_STACK_PTR] = sub_lit(ptr[`SLO_STACK_PTR], lit6);
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= slo_pkg::EX_RUN;
            op_kind <= slo_pkg::OP_NONE;
            op_word <= 16'h0000;
            for (int i = 0; i < 3; i++) begin
                ptr[i] <= PTR_W'(`SLO_PTR_RESET);
            end
        end else begin
            state <= next_state;
            op_kind <= next_op_kind;
            if (accept) begin
                op_word <= i_opcode;
            end
            for (int i = 0; i < 3; i++) begin
                ptr[i] <= next_ptr[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Memory write and return
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_mem_write <= 1'b0;
            o_mem_addr <= PTR_W'(`SLO_PTR_RESET);
            o_mem_wdata <= 8'h00;
            o_pc_load <= 1'b0;
            o_pc_value <= '0;
        end else begin
            o_mem_write <= exec_push;
            if (exec_push) begin
                o_mem_addr <= ptr[`SLO_STACK_PTR];
                o_mem_wdata <= lit8;
            end
            o_pc_load <= exec_ret;
            if (exec_ret) begin
                o_pc_value <= i_return_stack_top;
            end
        end
    end

    assign o_status_write = 1'b0;
    assign o_pointer0 = ptr[0];
    assign o_pointer1 = ptr[1];
    assign o_pointer2 = ptr[2];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    sequence s_take_push;
        accept && dec_kind == slo_pkg::OP_PUSH && !i_ptr_load;
    endsequence

    sequence s_take_ret;
        accept && dec_kind == slo_pkg::OP_SUBRET;
    endsequence

    a_push_literal_write: assert property (s_take_push |-> ##4 o_mem_write && o_mem_wdata == $past(i_opcode[7:0], 4))
        else $error("push literal not written");
    a_push_addr_old: assert property (exec_push |=> o_mem_addr == $past(ptr[2]) && ptr[2] == o_mem_addr - 12'h001)
        else $error("push address or decrement wrong");
    a_push_one_cycle: assert property (s_take_push |-> ##4 o_mem_write && o_op_ready ##1 !o_mem_write)
        else $error("push not single cycle");
    a_sub_selected: assert property (exec_sub && !i_ptr_load |=> ptr[$past(sel)] == $past(ptr[sel]) - {6'h00, $past(lit6)})
        else $error("pointer subtract wrong");
    a_ret_stack_only: assert property (exec_ret && !i_ptr_load |=> ptr[2] == $past(ptr[2]) - {6'h00, $past(lit6)} && $stable(ptr[0]))
        else $error("return subtract wrong");
    a_ret_pc_load: assert property (s_take_ret |-> ##4 o_pc_load && o_pc_value == $past(i_return_stack_top))
        else $error("return not taken");
    a_ret_nop_cycle: assert property (s_take_ret |-> ##4 (!o_op_ready && !o_mem_write) [*4] ##1 o_op_ready)
        else $error("second cycle not idle");
    a_sel_escape: assert property (accept && i_ext_enable && i_opcode[15:6] == {`SLO_OP_SUB_HI, 2'h3} |-> dec_kind == slo_pkg::OP_SUBRET)
        else $error("select 11 misdecoded");
    a_ext_gate: assert property (accept && !i_ext_enable |-> !o_op_taken ##4 !o_mem_write && !o_pc_load)
        else $error("decoded with extension off");
    a_flags_kept: assert property (exec |-> !o_status_write ##1 !o_status_write)
        else $error("status flags written");

endmodule

`default_nettype wire

// ### pkg/slo_defines.svh
/*
 * Constants of the stack pointer literal instruction block.
 * Assumes inclusion by bare name from the top design file only.
 */
`ifndef SLO_DEFINES_SVH
`define SLO_DEFINES_SVH

// ----------------------------------------------------------------
// Opcode fields
// ----------------------------------------------------------------
`define SLO_OP_PUSH_HI 8'hFA
`define SLO_OP_SUB_HI 8'hE9
`define SLO_SEL_RETURN 2'h3
`define SLO_SEL_MAX 2'h2
`define SLO_LIT8_MSB 7
`define SLO_LIT6_MSB 5
`define SLO_SEL_MSB 7
`define SLO_SEL_LSB 6

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define SLO_PTR_RESET 12'h000
`define SLO_PUSH_STEP 12'h001
`define SLO_STACK_PTR 2
`define SLO_PHASES 4

`endif

// ### pkg/slo_pkg.sv
/*
 * Types of the stack pointer literal instruction block.
 * Assumes nothing beyond the constants header.
 */
package slo_pkg;

    // Four phases of one instruction cycle
    typedef enum logic [1:0] {
        PH_Q1,
        PH_Q2,
        PH_Q3,
        PH_Q4
    } slo_phase_t;

    // Decoded instruction kind
    typedef enum logic [1:0] {
        OP_NONE,
        OP_PUSH,
        OP_SUB,
        OP_SUBRET
    } slo_op_t;

    // Execution state
    typedef enum logic {
        EX_RUN,
        EX_NOP
    } slo_exec_t;

endpackage

// ### pkg/slo_phase_if.sv
/*
 * Phase carrier between the phase sequencer and the executing core.
 * Assumes both ends share i_clock.
 */
`timescale 1ns/100ps
`default_nettype none

interface slo_phase_if;
    slo_pkg::slo_phase_t phase;
    logic cycle_end;

    modport seq (
        output phase,
        output cycle_end
    );
    modport core (
        input phase,
        input cycle_end
    );
endinterface

`default_nettype wire

// ### verilog/slo_phase_seq.sv
/*
 * Phase sequencer: steps Q1..Q4 once per instruction cycle.
 * Assumes one i_clock edge per phase and the core asynchronous reset.
 */
`timescale 1ns/100ps
`default_nettype none

module slo_phase_seq (
    input wire logic i_clock,
    input wire logic i_rst_n,
    slo_phase_if.seq phs
);

    slo_pkg::slo_phase_t phase;
    slo_pkg::slo_phase_t next_phase;

    always_comb begin
        case (phase)
            slo_pkg::PH_Q1: next_phase = slo_pkg::PH_Q2;
            slo_pkg::PH_Q2: next_phase = slo_pkg::PH_Q3;
            slo_pkg::PH_Q3: next_phase = slo_pkg::PH_Q4;
            default: next_phase = slo_pkg::PH_Q1;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phase <= slo_pkg::PH_Q1;
        end else begin
            phase <= next_phase;
        end
    end

    assign phs.phase = phase;
    assign phs.cycle_end = (phase == slo_pkg::PH_Q4);

endmodule

`default_nettype wire

// ### dv/test_stack_pointer_literal_ops.sv
/*
 * Self-checking bench of the stack pointer literal instruction block.
 * Assumes slo_top with its phase sequencer, Q1 first after reset.
 */
`timescale 1ns/100ps
`default_nettype none

module test_stack_pointer_literal_ops;
    logic i_clock, i_rst_n, i_ext_enable, i_op_valid, i_ptr_load;
    logic [15:0] i_opcode;
    logic [20:0] i_return_stack_top;
    logic [1:0] i_ptr_load_sel;
    logic [11:0] i_ptr_load_value;
    wire logic o_op_ready, o_op_taken, o_mem_write, o_pc_load, o_status_write;
    wire logic [11:0] o_mem_addr, o_pointer0, o_pointer1, o_pointer2;
    wire logic [7:0] o_mem_wdata;
    wire logic [20:0] o_pc_value;
    int num_errors = 0;
    int n_compared = 0;

    slo_top #(.PTR_W(12), .PC_W(21)) u_slo_top (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_ext_enable(i_ext_enable),
        .i_op_valid(i_op_valid), .i_opcode(i_opcode),
        .i_return_stack_top(i_return_stack_top), .i_ptr_load(i_ptr_load),
        .i_ptr_load_sel(i_ptr_load_sel), .i_ptr_load_value(i_ptr_load_value),
        .o_op_ready(o_op_ready), .o_op_taken(o_op_taken), .o_mem_write(o_mem_write),
        .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_pc_load(o_pc_load),
        .o_pc_value(o_pc_value), .o_status_write(o_status_write),
        .o_pointer0(o_pointer0), .o_pointer1(o_pointer1), .o_pointer2(o_pointer2)
    );

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (num_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    function automatic logic [11:0] ptr(input int sel);
        return (sel == 0) ? o_pointer0 : (sel == 1) ? o_pointer1 : o_pointer2;
    endfunction

    // Offer until a Q1 edge takes it; returns at that edge
    task automatic issue(input logic [15:0] op, output logic taken);
        int i;
        @(posedge i_clock);
        i_op_valid <= 1'b1;
        i_opcode <= op;
        for (i = 0; i < 12; i++) begin
            @(negedge i_clock);
            if (o_op_ready === 1'b1) break;
        end
        if (i == 12) begin
            num_errors++;
            close_out();
        end
        taken = o_op_taken;
        @(posedge i_clock);
        i_op_valid <= 1'b0;
    endtask

    // Settle into the cycle four after the take
    task automatic to_result();
        repeat (3) @(posedge i_clock);
        @(negedge i_clock);
    endtask

    task automatic load_ptr(input logic [1:0] sel, input logic [11:0] val);
        @(posedge i_clock);
        i_ptr_load <= 1'b1;
        i_ptr_load_sel <= sel;
        i_ptr_load_value <= val;
        @(posedge i_clock);
        i_ptr_load <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_push();
        logic tk;
        load_ptr(2'h2, 12'h1EC);
        issue(16'hFA08, tk);
        check(32'(tk), 32'h1);
        to_result();
        check(32'(o_mem_write), 32'h1);
        check(32'(o_mem_addr), 32'h1EC);
        check(32'(o_mem_wdata), 32'h08);
        check(32'(o_pointer2), 32'h1EB);
        check(32'(o_status_write), 32'h0);
        @(negedge i_clock);
        check(32'(o_mem_write), 32'h0);
        issue(16'hFAFF, tk);
        to_result();
        check(32'(o_mem_addr), 32'h1EB);
        check(32'(o_mem_wdata), 32'hFF);
        check(32'(o_pointer2), 32'h1EA);
    endtask

    task automatic t_sub();
        logic tk;
        logic [5:0] k;
        logic [11:0] other;
        for (int f = 0; f < 3; f++) begin
            k = (f == 0) ? 6'h3F : (f == 1) ? 6'h01 : 6'h23;
            load_ptr(2'(f), 12'h3FF);
            other = ptr((f + 1) % 3);
            issue({8'hE9, 2'(f), k}, tk);
            check(32'(tk), 32'h1);
            to_result();
            check(32'(ptr(f)), 32'(12'h3FF - {6'h00, k}));
            check(32'(ptr((f + 1) % 3)), 32'(other));
            check(32'(o_status_write), 32'h0);
        end
    endtask

    task automatic t_subret();
        logic tk;
        load_ptr(2'h2, 12'h3FF);
        load_ptr(2'h0, 12'h123);
        @(posedge i_clock);
        i_return_stack_top <= 21'h1ABCD;
        issue(16'hE9E3, tk);
        check(32'(tk), 32'h1);
        to_result();
        check(32'(o_pc_load), 32'h1);
        check(32'(o_pc_value), 32'h1ABCD);
        check(32'(o_pointer2), 32'h3DC);
        check(32'(o_pointer0), 32'h123);
        for (int c = 0; c < 4; c++) begin
            check(32'(o_op_ready), 32'h0);
            @(negedge i_clock);
            check(32'(o_pc_load), 32'h0);
        end
        check(32'(o_op_ready), 32'h1);
    endtask

    task automatic t_refuse();
        logic tk;
        logic [11:0] p;
        @(posedge i_clock);
        i_ext_enable <= 1'b0;
        p = o_pointer2;
        issue(16'hFA33, tk);
        check(32'(tk), 32'h0);
        to_result();
        check(32'(o_mem_write), 32'h0);
        check(32'(o_pointer2), 32'(p));
        load_ptr(2'h3, 12'h555);
        @(negedge i_clock);
        check(32'(o_pointer2), 32'(p));
        @(posedge i_clock);
        i_ext_enable <= 1'b1;
        issue(16'hE8E3, tk);
        check(32'(tk), 32'h0);
        to_result();
        check(32'(o_pointer2), 32'(p));
    endtask

    // ----------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------------------------------
    initial begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end

    initial begin
        repeat (4000) @(posedge i_clock);
        num_errors++;
        close_out();
    end

    initial begin
        i_rst_n = 1'b0;
        i_ext_enable = 1'b1;
        i_op_valid = 1'b0;
        i_opcode = 16'h0000;
        i_return_stack_top = 21'h000000;
        i_ptr_load = 1'b0;
        i_ptr_load_sel = 2'h0;
        i_ptr_load_value = 12'h000;
        repeat (6) @(posedge i_clock);
        check(32'(o_status_write), 32'h0);
        check(32'(o_mem_write), 32'h0);
        i_rst_n <= 1'b1;
        t_push();
        t_sub();
        t_subret();
        t_refuse();
        close_out();
    end
endmodule

`default_nettype wire
